// ---- dac_word_pkg.sv ----
// Shared constants and types for the serial converter word link.
package dac_word_pkg;
    localparam int          WORD_BITS      = 16;
    localparam int          CNT_BITS       = 5;
    localparam logic [15:0] LATCH_RST      = 16'h0000;
    localparam logic [15:0] BIPOLAR_MID    = 16'h8000;
    localparam logic [4:0]  BIT_CNT_RST    = 5'h00;
    localparam logic [4:0]  BIT_CNT_FULL   = 5'h10;
    localparam logic [3:0]  CLK_DIV_HALF   = 4'h8;
    localparam logic [3:0]  DIV_CNT_RST    = 4'h0;
    localparam logic [2:0]  SYNC_RST_HIGH  = 3'h7;
    localparam logic [2:0]  SYNC_RST_LOW   = 3'h0;
    localparam logic [3:0]  STROBE_HOLD    = 4'h4;

    typedef enum logic [4:0] {
        H_IDLE   = 5'b00001,
        H_SELECT = 5'b00010,
        H_LOW    = 5'b00100,
        H_HIGH   = 5'b01000,
        H_DONE   = 5'b10000
    } host_state_e;
endpackage

// ---- dac_link_if.sv ----
// Pins between the serial host and the converter word loader.
interface dac_link_if;
    logic sclk;
    logic sdata;
    logic sel_n;
    logic latch_load_strobe_n;

    modport host (
        output sclk,
        output sdata,
        output sel_n,
        output latch_load_strobe_n
    );
    modport dev (
        input  sclk,
        input  sdata,
        input  sel_n,
        input  latch_load_strobe_n
    );
endinterface

// ---- pin_sync3.sv ----
// Three-stage synchroniser with agreement filter for one pin.
module pin_sync3
    import dac_word_pkg::*;
#(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic clk_en,
    input  wire logic pin,
    output logic      level
);
    logic [2:0] sync_ff;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sync_ff <= RST_VAL ? SYNC_RST_HIGH : SYNC_RST_LOW;
        end else if (clk_en) begin
            sync_ff <= {sync_ff[1:0], pin};
        end
    end

    // Only the second and third stages are looked at; the level changes
    // once they agree, which rejects a single-sample glitch.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            level <= RST_VAL;
        end else if (clk_en && (sync_ff[1] == sync_ff[2])) begin
            level <= sync_ff[2];
        end
    end
endmodule

// ---- dac_word_dev.sv ----
// Device end: serial shift register and converter latch.
// Notes on behaviour
// - Latch holds zeros until first transfer.
// - Shift register is not cleared at power-up.
// - Long frames keep the last sixteen bits.
// - Short frames leave older bits in place.
// - Host loads sixteen bits first after power-up.
// - Host pads short data with low zeros.
// - Sixteen-bit words sampled on rising clock.
// - Latch updates automatically or by strobe.
// - Falling-edge launching host connects directly.
// - Master idles clock low, samples first edge.
// - Latch code is straight offset binary.
// - Select low frames data, MSB first.
// - Select rising after sixteen bits loads latch.
// - Strobe high while shifting; low loads latch.
module dac_word_dev
    import dac_word_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    dac_link_if.dev          link,
    output logic [15:0]      latch_code_ff,
    output logic             latch_update_ff,
    output logic             bipolar_neg_ff,
    output logic             bipolar_zero_ff,
    output logic [4:0]       frame_bits_ff
);
    logic sclk_lvl;
    logic sdata_lvl;
    logic sel_n_lvl;
    logic strobe_n_lvl;
    logic sclk_d_ff;
    logic sel_n_d_ff;
    logic strobe_n_d_ff;
    logic sclk_rise;
    logic sel_rise;
    logic strobe_fall;
    logic [15:0] shift_ff;
    logic [15:0] nxt_latch;
    logic        load_now;
    logic        pending_ff;
    logic        sel_fall;
    logic [15:0] nxt_shift;
    logic [4:0]  nxt_frame_bits;
    logic        nxt_pending;

    pin_sync3 #(.RST_VAL(1'b0)) u_sclk (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .clk_en  (clk_en),
        .pin     (link.sclk),
        .level   (sclk_lvl)
    );
    pin_sync3 #(.RST_VAL(1'b0)) u_sdata (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .clk_en  (clk_en),
        .pin     (link.sdata),
        .level   (sdata_lvl)
    );
    pin_sync3 #(.RST_VAL(1'b1)) u_sel (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .clk_en  (clk_en),
        .pin     (link.sel_n),
        .level   (sel_n_lvl)
    );
    pin_sync3 #(.RST_VAL(1'b1)) u_strobe (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .clk_en  (clk_en),
        .pin     (link.latch_load_strobe_n),
        .level   (strobe_n_lvl)
    );

    // Reset values match the idle level of each pin, so no false edge
    // follows reset; a frozen edge still counts only once on resuming.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sclk_d_ff <= 1'b0;
        end else if (clk_en) begin
            sclk_d_ff <= sclk_lvl;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sel_n_d_ff <= 1'b1;
        end else if (clk_en) begin
            sel_n_d_ff <= sel_n_lvl;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            strobe_n_d_ff <= 1'b1;
        end else if (clk_en) begin
            strobe_n_d_ff <= strobe_n_lvl;
        end
    end

    // Data and clock pass equal filters, so data is aligned with its edge.
    assign sclk_rise   = sclk_lvl && !sclk_d_ff && !sel_n_lvl;
    assign sel_rise    = sel_n_lvl && !sel_n_d_ff;
    assign strobe_fall = !strobe_n_lvl && strobe_n_d_ff;
    assign sel_fall    = !sel_n_lvl && sel_n_d_ff;

    // No reset: the word is undefined until shifted in.
    always_comb begin
        nxt_shift = shift_ff;
        if (sclk_rise) begin
            nxt_shift = {shift_ff[14:0], sdata_lvl};
        end
    end

    // Leaving out the reset saves sixteen reset loads; the price is that a
    // short first frame shows unknown bits, which the host must avoid.
    always_ff @(posedge sys_clk) begin
        if (clk_en) begin
            shift_ff <= nxt_shift;
        end
    end

    // Counts bits in the current frame, saturating at sixteen so that an
    // overlong frame cannot wrap back to a small count.
    always_comb begin
        nxt_frame_bits = frame_bits_ff;
        if (sel_fall) begin
            nxt_frame_bits = BIT_CNT_RST;
        end else if (sclk_rise && frame_bits_ff != BIT_CNT_FULL) begin
            nxt_frame_bits = frame_bits_ff + 5'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            frame_bits_ff <= BIT_CNT_RST;
        end else if (clk_en) begin
            frame_bits_ff <= nxt_frame_bits;
        end
    end

    // With the strobe held high at frame end the word waits in the shift
    // register until the strobe falls; with it held low, select loads.
    // A new frame drops a word still waiting, as it is being overwritten.
    always_comb begin
        nxt_pending = pending_ff;
        if (sel_rise && strobe_n_lvl) begin
            nxt_pending = 1'b1;
        end else if (load_now || !sel_n_lvl) begin
            nxt_pending = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pending_ff <= 1'b0;
        end else if (clk_en) begin
            pending_ff <= nxt_pending;
        end
    end

    always_comb begin
        load_now = 1'b0;
        if (sel_rise && !strobe_n_lvl) begin
            load_now = 1'b1;
        end else if (pending_ff && strobe_fall && sel_n_lvl) begin
            load_now = 1'b1;
        end
        nxt_latch = load_now ? shift_ff : latch_code_ff;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            latch_code_ff <= LATCH_RST;
        end else if (clk_en) begin
            latch_code_ff <= nxt_latch;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            latch_update_ff <= 1'b0;
        end else if (clk_en) begin
            latch_update_ff <= load_now;
        end
    end

    // The flags follow the next latch value, so they change in the same
    // cycle as the code and never show a stale pair.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            bipolar_neg_ff <= 1'b1;
        end else if (clk_en) begin
            bipolar_neg_ff <= !nxt_latch[15];
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            bipolar_zero_ff <= 1'b0;
        end else if (clk_en) begin
            bipolar_zero_ff <= (nxt_latch == BIPOLAR_MID);
        end
    end
endmodule

// ---- dac_word_host.sv ----
// Host end: serial master that sends one sixteen-bit word per request.
module dac_word_host
    import dac_word_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    input  wire logic        send_req,
    input  wire logic [15:0] send_word,
    input  wire logic        use_strobe,
    dac_link_if.host         link,
    output logic             busy_ff,
    output logic             done_ff
);
    host_state_e state_ff;
    logic [15:0] word_ff;
    logic [4:0]  bits_ff;
    logic [3:0]  div_ff;
    logic        sclk_ff;
    logic        sel_n_ff;
    logic        strobe_n_ff;
    logic        strobe_mode_ff;
    logic        tick;

    assign tick = (div_ff == CLK_DIV_HALF - 4'h1);
    assign link.sclk  = sclk_ff;
    assign link.sdata = word_ff[15];
    assign link.sel_n = sel_n_ff;
    assign link.latch_load_strobe_n = strobe_n_ff;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            div_ff <= DIV_CNT_RST;
        end else if (clk_en) begin
            div_ff <= (tick || state_ff == H_IDLE) ? DIV_CNT_RST
                                                   : div_ff + 4'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff       <= H_IDLE;
            word_ff        <= LATCH_RST;
            bits_ff        <= BIT_CNT_RST;
            sclk_ff        <= 1'b0;
            sel_n_ff       <= 1'b1;
            strobe_n_ff    <= 1'b1;
            strobe_mode_ff <= 1'b0;
            busy_ff        <= 1'b0;
            done_ff        <= 1'b0;
        end else if (clk_en) begin
            done_ff <= 1'b0;
            case (state_ff)
                H_IDLE: begin
                    if (send_req) begin
                        word_ff        <= send_word;
                        bits_ff        <= BIT_CNT_RST;
                        strobe_mode_ff <= use_strobe;
                        strobe_n_ff    <= !use_strobe ? 1'b0 : 1'b1;
                        sel_n_ff       <= 1'b0;
                        busy_ff        <= 1'b1;
                        state_ff       <= H_SELECT;
                    end
                end
                H_SELECT: begin
                    if (tick) begin
                        state_ff <= H_LOW;
                    end
                end
                // Data changes only on falling edges or as select falls, idle low clock.
                H_LOW: begin
                    if (tick) begin
                        sclk_ff  <= 1'b1;
                        bits_ff  <= bits_ff + 5'h01;
                        state_ff <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (tick) begin
                        sclk_ff <= 1'b0;
                        if (bits_ff == BIT_CNT_FULL) begin
                            state_ff <= H_DONE;
                        end else begin
                            word_ff  <= {word_ff[14:0], 1'b0};
                            state_ff <= H_LOW;
                        end
                    end
                end
                H_DONE: begin
                    if (tick) begin
                        if (!sel_n_ff && !strobe_mode_ff) begin
                            sel_n_ff <= 1'b1;
                            state_ff <= H_IDLE;
                            busy_ff  <= 1'b0;
                            done_ff  <= 1'b1;
                        end else if (!sel_n_ff) begin
                            sel_n_ff <= 1'b1;
                        end else if (strobe_n_ff) begin
                            strobe_n_ff <= 1'b0;
                        end else begin
                            strobe_n_ff <= 1'b1;
                            state_ff    <= H_IDLE;
                            busy_ff     <= 1'b0;
                            done_ff     <= 1'b1;
                        end
                    end
                end
                default: begin
                    state_ff <= H_IDLE;
                end
            endcase
        end
    end
endmodule

// ---- dac_link_assertions.sv ----
// Protocol checks on the serial link between host and device ends.
module dac_link_assertions
    import dac_word_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic sclk,
    input wire logic sdata,
    input wire logic sel_n,
    input wire logic latch_load_strobe_n
);
    logic [4:0] rise_cnt_ff;
    logic       sclk_d_ff;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sclk_d_ff <= 1'b0;
        end else begin
            sclk_d_ff <= sclk;
        end
    end

    // Counting rises per frame catches a host that sends 15 or 17 bits.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rise_cnt_ff <= BIT_CNT_RST;
        end else if (sel_n) begin
            rise_cnt_ff <= BIT_CNT_RST;
        end else if (sclk && !sclk_d_ff) begin
            rise_cnt_ff <= rise_cnt_ff + 5'h01;
        end
    end

    a_sclk_idle_low: assert property (sel_n |-> !sclk)
        else $error("serial clock high while deselected");
    a_frame_lead: assert property ($fell(sel_n) |->
        !sclk[*8] ##1 !sclk[*8] ##1 sclk)
        else $error("first clock rise not 16 cycles after select");
    a_data_steady: assert property ($rose(sclk) |->
        $stable(sdata) && !sel_n)
        else $error("data moved at clock rise");
    a_clk_high_time: assert property ($rose(sclk) |-> sclk[*8] ##1 !sclk)
        else $error("clock high phase wrong");
    a_clk_low_time: assert property ($fell(sclk) |-> !sclk[*8])
        else $error("clock low phase too short");
    a_word_bits: assert property ($rose(sel_n) |->
        rise_cnt_ff == BIT_CNT_FULL && !$past(sclk, 8))
        else $error("frame did not carry sixteen bits");
    a_strobe_frame: assert property (!sel_n && !$past(sel_n) |->
        $stable(latch_load_strobe_n))
        else $error("load strobe moved inside a frame");
    a_strobe_pulse: assert property ($fell(latch_load_strobe_n)
        && sel_n |-> !latch_load_strobe_n[*8] ##1 latch_load_strobe_n)
        else $error("load strobe pulse width wrong");
endmodule

// ---- dac_serial_word_loader_tb.sv ----
// Self-checking bench for the serial word host and device pair.
module dac_serial_word_loader_tb;
    import dac_word_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        send_req = 1'b0;
    logic [15:0] send_word = 16'h0000;
    logic        use_strobe = 1'b0;
    logic        busy_ff, done_ff, upd, upd2, neg, zro, fchk;
    logic [15:0] code, code2, e1, w;
    logic [15:0] q1[$], q2[$], words[8];
    int          miscompares = 0;
    int          n_compared = 0;
    int          n_done = 0;
    logic        clk_en = 1'b1;
    logic [4:0]  fb, fb2;
    int          k;
    dac_link_if  lk();
    dac_link_if  lk2();
    always #2 sys_clk = ~sys_clk;
    dac_word_host dac_word_host_i (.sys_clk(sys_clk), .resetn(resetn),
        .clk_en(clk_en), .send_req(send_req), .send_word(send_word),
        .use_strobe(use_strobe), .link(lk.host), .busy_ff(busy_ff),
        .done_ff(done_ff));
    dac_word_dev dac_word_dev_i (.sys_clk(sys_clk), .resetn(resetn),
        .clk_en(clk_en), .link(lk.dev), .latch_code_ff(code),
        .latch_update_ff(upd), .bipolar_neg_ff(neg),
        .bipolar_zero_ff(zro), .frame_bits_ff(fb));
    // Second device faces the bench, which breaks frame lengths on purpose.
    dac_word_dev dac_word_dev_i2 (.sys_clk(sys_clk), .resetn(resetn),
        .clk_en(clk_en), .link(lk2.dev), .latch_code_ff(code2),
        .latch_update_ff(upd2), .bipolar_neg_ff(), .bipolar_zero_ff(),
        .frame_bits_ff(fb2));
    dac_link_assertions dac_link_assertions_i (.sys_clk(sys_clk),
        .resetn(resetn), .sclk(lk.sclk), .sdata(lk.sdata),
        .sel_n(lk.sel_n), .latch_load_strobe_n(lk.latch_load_strobe_n));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wrap_up;
        $display("compared %0d bad %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task send(input logic [15:0] v, input logic s);
        send_req <= 1'b1;
        send_word <= v;
        use_strobe <= s;
        q1.push_back(v);
        for (k = 0; k < 1000 && busy_ff !== 1'b1; k++) cyc(1);
        send_req <= 1'b0;
        for (; k < 1000 && busy_ff === 1'b1; k++) cyc(1);
        if (k >= 1000) begin
            miscompares++;
            wrap_up();
        end
    endtask
    task frame2(input logic [31:0] v, input int n, input logic stb);
        lk2.latch_load_strobe_n <= stb;
        lk2.sel_n <= 1'b0;
        cyc(8);
        for (int i = n - 1; i >= 0; i--) begin
            lk2.sdata <= v[i];
            cyc(8);
            lk2.sclk <= 1'b1;
            cyc(8);
            lk2.sclk <= 1'b0;
        end
        cyc(8);
        lk2.sel_n <= 1'b1;
        lk2.sdata <= ~v[0];
        cyc(16);
    endtask
    task strobe2;
        lk2.latch_load_strobe_n <= 1'b0;
        cyc(8);
        lk2.latch_load_strobe_n <= 1'b1;
        cyc(16);
    endtask
    // A load with no note queued is itself a mismatch.
    task automatic mon(ref logic [15:0] q[$], input logic [15:0] c);
        e1 = (q.size() > 0) ? q.pop_front() : ~c;
        chk(c, e1);
    endtask
    // Flags are read a cycle late so either register timing is accepted.
    always @(negedge sys_clk) begin
        if (fchk === 1'b1) begin
            chk({15'h0000, neg}, {15'h0000, ~e1[15]});
            chk({15'h0000, zro}, {15'h0000, e1 == BIPOLAR_MID});
        end
        fchk = 1'b0;
        if (upd === 1'b1) begin
            mon(q1, code);
            fchk = 1'b1;
        end
        if (upd2 === 1'b1) mon(q2, code2);
        if (done_ff === 1'b1) n_done++;
    end

    initial begin
        lk2.sclk = 1'b0;
        lk2.sdata = 1'b0;
        lk2.sel_n = 1'b1;
        lk2.latch_load_strobe_n = 1'b1;
        void'($urandom(32'h1968));
        words = '{16'hFFFF, 16'h8000, 16'h7FFF, 16'h0000, 16'h8001,
                  16'hABC0, 16'($urandom), 16'($urandom)};
        cyc(5);
        resetn <= 1'b1;
        cyc(2);
        chk(code, LATCH_RST);
        chk(code2, LATCH_RST);
        // The 16'hABC0 entry is a twelve-bit value padded with low zeros.
        foreach (words[i]) begin
            send(words[i], i[0]);
            chk({11'h000, fb}, {11'h000, BIT_CNT_FULL});
        end
        chk(16'(n_done), 16'h0008);
        $display("test host words done");
        q2.push_back(16'h5A3C);
        frame2(32'h0000_5A3C, 16, 1'b0);
        chk({11'h000, fb2}, 16'h0010);
        q2.push_back(16'h1234);
        frame2(32'h000F_1234, 20, 1'b0);
        chk({11'h000, fb2}, 16'h0010);
        q2.push_back(16'h3499);
        frame2(32'h0000_0099, 8, 1'b0);
        chk({11'h000, fb2}, 16'h0008);
        $display("test frame lengths done");
        repeat (4) begin
            lk2.sclk <= 1'b1;
            lk2.sdata <= 1'($urandom);
            cyc(8);
            lk2.sclk <= 1'b0;
            cyc(8);
        end
        q2.push_back(16'h995A);
        frame2(32'h0000_005A, 8, 1'b0);
        // Frozen ends ignore a whole frame and keep their shift register.
        clk_en <= 1'b0;
        frame2(32'h0000_FFFF, 16, 1'b0);
        clk_en <= 1'b1;
        cyc(16);
        q2.push_back(16'h5A3C);
        frame2(32'h0000_003C, 8, 1'b0);
        w = 16'($urandom);
        frame2({16'h0000, w}, 16, 1'b1);
        cyc(40);
        q2.push_back(w);
        strobe2();
        strobe2();
        $display("test strobe and deselect done");
        for (k = 0; k < 200 && (q1.size() > 0 || q2.size() > 0); k++) cyc(1);
        if (k >= 200) miscompares++;
        wrap_up();
    end
endmodule
